// file: src/i2c_defines.vh
`ifndef I2C_DEFINES_VH
`define I2C_DEFINES_VH

// Register byte offsets on the APB bus.
`define OFS_PORT_CONTROL 8'h00
`define OFS_PORT_STATUS 8'h04
`define OFS_SLAVE_ADDRESS 8'h08
`define OFS_SHIFT_BUFFER 8'h0C
`define OFS_EVENT_FLAGS 8'h10

// Field positions in port_control.
`define CTL_COLLIDE 7
`define CTL_ROV 6
`define CTL_EN 5
`define CTL_RELEASE 4

// Field positions in port_status.
`define STA_SAMPLE 7
`define STA_CKE 6
`define STA_DA 5
`define STA_STOP 4
`define STA_START 3
`define STA_RW 2
`define STA_UPDATE 1
`define STA_FULL 0

// Reset values.
`define RST_PORT_CONTROL 8'h00
`define RST_PORT_STATUS 8'h00
`define RST_ADDRESS_MASK 8'hFF
`define RST_SLAVE_ADDRESS 8'h00
`define RST_SHIFT_BUFFER 8'h00

// Mode field codes.
`define MODE_SLV7 4'h6
`define MODE_SLV10 4'h7
`define MODE_MASK_ACCESS 4'h9
`define MODE_FW_MASTER 4'hB
`define MODE_SLV7_SP 4'hE
`define MODE_SLV10_SP 4'hF

// Bit clock counts within a byte.
`define BITS_PER_BYTE 4'h8
`define ACK_BIT 4'h9

`endif

// file: src/i2c_slave_serial_port.v
// Overview of operation
// - Buffer write during an ongoing transmit sets write collision; software clears it.
// - Byte arriving while buffer still full sets overflow; software clears it.
// - Enable bit hands SDA and SCL to the port; clear returns them.
// - Clock-release bit low stretches SCL before a transmitted byte; writing it high releases SCL.
// - Mode field picks 7-bit slave, 10-bit slave or firmware master, slave idle.
// - Modes 1110 and 1111 are slaves that also flag Start and Stop.
// - In mode 1001 the slave-address location reaches the address mask.
// - Data-or-address bit shows whether the last received byte was data or address.
// - Stop-seen bit set by Stop, cleared by Start, disable and reset.
// - Start-seen bit set by Start, cleared by Stop, disable and reset.
// - Read/write bit holds the direction of the last matched address until the next Start or Stop.
// - Ten-bit modes set the address-update flag asking for a new address.
// - Receive: buffer-full set when a byte completes, clear when emptied.
// - Transmit: buffer-full set while loaded, clear once the byte is sent.
// - Sample-phase bit selects slew limiting: one off, zero on for fast mode.
// - Mask bits 7 to 1 choose which address bits take part in matching.
// - Mask bit 0 matters only in 10-bit slave mode 0111.
// - Buffer-full clears at the 8th falling edge; interrupt flag at the ninth.
// - After a read match the device acknowledges and stretches until release.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_defines.vh"

module i2c_slave_serial_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output wire pins_to_port,
  output wire slew_limit_en
);

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACK = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_TX = 3'd4;
  localparam S_TXACK = 3'd5;
  localparam S_ADDR2 = 3'd6;

  // Seven-bit slave modes, with or without Start and Stop flags.
  function is_slv7;
    input [3:0] m;
    begin
      is_slv7 = (m == `MODE_SLV7) || (m == `MODE_SLV7_SP);
    end
  endfunction

  // Ten-bit slave modes, with or without Start and Stop flags.
  function is_slv10;
    input [3:0] m;
    begin
      is_slv10 = (m == `MODE_SLV10) || (m == `MODE_SLV10_SP);
    end
  endfunction

  // Masked compare; bit 0 takes part only in plain 10-bit mode.
  function addr_match;
    input [7:0] rx;
    input [7:0] adr;
    input [7:0] msk;
    input [3:0] m;
    reg [7:0] care;
    begin
      care = {msk[7:1], (m == `MODE_SLV10) ? msk[0] : 1'b0};
      addr_match = ((rx ^ adr) & care) == 8'h00;
    end
  endfunction

  reg [7:0] ctrl_q;
  reg sample_phase_q;
  reg cke_q;
  reg da_q;
  reg stop_q;
  reg start_q;
  reg rw_q;
  reg upd_addr_q;
  reg buf_full_q;
  reg [7:0] mask_q;
  reg [7:0] addr_q;
  reg [7:0] buf_q;
  reg if_q;
  reg [2:0] state_q;
  reg [2:0] after_ack_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg ten_done_q;
  reg nack_q;
  reg scl_hold_q;
  reg sda_low_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;

  // Both bus lines come from outside the clock domain.
  line_sync u_scl_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(scl_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  line_sync u_sda_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din(sda_in),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  wire [3:0] mode = ctrl_q[3:0];
  wire en = ctrl_q[`CTL_EN];
  wire release_bit = ctrl_q[`CTL_RELEASE];
  wire slave = is_slv7(mode) | is_slv10(mode);
  wire ten = is_slv10(mode);
  wire sp_irq = (mode == `MODE_SLV7_SP) | (mode == `MODE_SLV10_SP) |
                (mode == `MODE_FW_MASTER);
  wire start_ev = en & sda_fall & scl_lvl;
  wire stop_ev = en & sda_rise & scl_lvl;
  wire byte_end = scl_fall & (cnt_q == `BITS_PER_BYTE);

  // APB decode; a request is answered after one wait cycle.
  wire access = psel & penable;
  wire done = access & pready_q;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire hit_ctl = paddr == `OFS_PORT_CONTROL;
  wire hit_sta = paddr == `OFS_PORT_STATUS;
  wire hit_adr = paddr == `OFS_SLAVE_ADDRESS;
  wire hit_buf = paddr == `OFS_SHIFT_BUFFER;
  wire hit_evt = paddr == `OFS_EVENT_FLAGS;
  wire mapped = hit_ctl | hit_sta | hit_adr | hit_buf | hit_evt;
  wire mask_sel = mode == `MODE_MASK_ACCESS;
  wire tx_busy = (state_q == S_TX) & release_bit;
  wire buf_wr = wr & hit_buf & en;
  wire buf_collide = buf_wr & tx_busy & buf_full_q;

  // Register read multiplexer.
  reg [7:0] rdata;
  always @* begin
    rdata = 8'h00;
    case (paddr)
      `OFS_PORT_CONTROL: rdata = ctrl_q;
      `OFS_PORT_STATUS: begin
        rdata = {sample_phase_q, cke_q, da_q, stop_q, start_q, rw_q, upd_addr_q, buf_full_q};
      end
      `OFS_SLAVE_ADDRESS: rdata = mask_sel ? mask_q : addr_q;
      `OFS_SHIFT_BUFFER: rdata = buf_q;
      `OFS_EVENT_FLAGS: rdata = {7'h00, if_q};
      default: rdata = 8'h00;
    endcase
  end

  // Bus answer; unmapped addresses end with an error and read zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (access & ~pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= {24'h00_0000, rdata};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Software-owned registers and the mask, address and sample-phase bits.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_phase_q <= 1'b0;
      cke_q <= 1'b0;
      mask_q <= `RST_ADDRESS_MASK;
      addr_q <= `RST_SLAVE_ADDRESS;
    end else begin
      if (wr & hit_sta) begin
        sample_phase_q <= pwdata[`STA_SAMPLE];
        cke_q <= pwdata[`STA_CKE];
      end
      if (wr & hit_adr & mask_sel) begin
        mask_q <= pwdata[7:0];
      end
      if (wr & hit_adr & ~mask_sel) begin
        addr_q <= pwdata[7:0];
      end
    end
  end

  // Slave engine, status flags and the control register.
  // Hardware sets of the sticky flags take priority over software clears,
  // so an event landing in the clearing cycle is never lost.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RST_PORT_CONTROL;
      da_q <= 1'b0;
      stop_q <= 1'b0;
      start_q <= 1'b0;
      rw_q <= 1'b0;
      upd_addr_q <= 1'b0;
      buf_full_q <= 1'b0;
      buf_q <= `RST_SHIFT_BUFFER;
      if_q <= 1'b0;
      state_q <= S_IDLE;
      after_ack_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ten_done_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      if (wr & hit_ctl) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wr & hit_evt & pwdata[0]) begin
        if_q <= 1'b0;
      end
      if (wr & hit_adr & ~mask_sel) begin
        upd_addr_q <= 1'b0;
      end
      if (rd & hit_buf & (state_q != S_TX) & (state_q != S_TXACK)) begin
        buf_full_q <= 1'b0;
      end
      if (buf_collide) begin
        ctrl_q[`CTL_COLLIDE] <= 1'b1;
      end else if (buf_wr) begin
        buf_q <= pwdata[7:0];
        buf_full_q <= 1'b1;
      end
      if (!en) begin
        // Disabling the port aborts any transfer and frees both lines.
        state_q <= S_IDLE;
        stop_q <= 1'b0;
        start_q <= 1'b0;
        sda_low_q <= 1'b0;
        ten_done_q <= 1'b0;
        cnt_q <= 4'h0;
      end else if (start_ev) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
        rw_q <= 1'b0;
        if (sp_irq) if_q <= 1'b1;
        sda_low_q <= 1'b0;
        cnt_q <= 4'h0;
        state_q <= slave ? S_ADDR : S_IDLE;
      end else if (stop_ev) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
        rw_q <= 1'b0;
        if (sp_irq) if_q <= 1'b1;
        sda_low_q <= 1'b0;
        ten_done_q <= 1'b0;
        state_q <= S_IDLE;
      end else begin
        case (state_q)
          S_ADDR, S_ADDR2, S_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_lvl};
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end) begin
              if (state_q == S_RX) begin
                if (buf_full_q) begin
                  ctrl_q[`CTL_ROV] <= 1'b1;
                  state_q <= S_IDLE;
                end else begin
                  buf_q <= sh_q;
                  buf_full_q <= 1'b1;
                  da_q <= 1'b1;
                  sda_low_q <= 1'b1;
                  after_ack_q <= S_RX;
                  state_q <= S_ACK;
                end
              end else if (addr_match(sh_q, addr_q, mask_q, mode)) begin
                // Ten-bit repeated Start with read goes straight to transmit.
                if (state_q == S_ADDR2 || !ten || (sh_q[0] & ten_done_q) ||
                    !sh_q[0]) begin
                  if (buf_full_q) ctrl_q[`CTL_ROV] <= 1'b1;
                  buf_q <= sh_q;
                  buf_full_q <= 1'b1;
                  da_q <= 1'b0;
                  rw_q <= sh_q[0] & (state_q == S_ADDR);
                  sda_low_q <= 1'b1;
                  state_q <= S_ACK;
                  if (ten && state_q == S_ADDR && !sh_q[0]) begin
                    upd_addr_q <= 1'b1;
                    after_ack_q <= S_ADDR2;
                  end else if (ten && state_q == S_ADDR2) begin
                    upd_addr_q <= 1'b1;
                    ten_done_q <= 1'b1;
                    after_ack_q <= S_RX;
                  end else begin
                    after_ack_q <= sh_q[0] ? S_TX : S_RX;
                  end
                end else begin
                  state_q <= S_IDLE;
                end
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_low_q <= 1'b0;
              if_q <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= after_ack_q;
              if (after_ack_q == S_TX) begin
                ctrl_q[`CTL_RELEASE] <= 1'b0;
                buf_full_q <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (cnt_q == 4'h0 && !scl_lvl) begin
              // First bit follows the buffer until the master clocks it.
              sh_q <= buf_q;
              sda_low_q <= ~buf_q[7];
            end
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (byte_end) begin
              sda_low_q <= 1'b0;
              buf_full_q <= 1'b0;
              state_q <= S_TXACK;
            end else if (scl_fall && cnt_q != 4'h0) begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_low_q <= ~sh_q[6];
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              nack_q <= sda_lvl;
              cnt_q <= `ACK_BIT;
            end else if (scl_fall && cnt_q == `ACK_BIT) begin
              if_q <= 1'b1;
              cnt_q <= 4'h0;
              if (nack_q) begin
                state_q <= S_IDLE;
              end else begin
                ctrl_q[`CTL_RELEASE] <= 1'b0;
                state_q <= S_TX;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Stretch only once SCL is already low, so the high time is never cut short.
  // The address-update stretch waits until the acknowledge clock is over,
  // otherwise the master could never clock in our acknowledge.
  wire stretch_req = en & slave & ((upd_addr_q & (state_q != S_ACK)) |
                     ((state_q == S_TX) & (cnt_q == 4'h0) & ~release_bit));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_hold_q <= 1'b0;
    end else begin
      scl_hold_q <= stretch_req & (scl_hold_q | ~scl_lvl);
    end
  end

  // Open-drain drive: the enables go low while the line is pulled down.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_hold_q;
  assign sda_oe_n = ~(sda_low_q & en);
  assign pins_to_port = en;
  assign slew_limit_en = ~sample_phase_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

`default_nettype wire

// file: src/line_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a bus line with edge detection behind it.
// The edge detector looks only at the second and third stages.
module line_sync (
  input wire clk,
  input wire rst_n,
  input wire din,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_q;
  reg sync_q;
  reg last_q;

  // Lines idle high, so every stage resets to one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edges of the synchronised level.
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule

`default_nettype wire

// file: tb/i2c_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m
);
  // Both lines released; the clock stands still outside frames.
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // One bit of 800 ns; a stretching slave is waited for, but only for a bounded time.
  task automatic bit_io(input logic b, output logic r);
    int n;
    sda_m = b;
    #200;
    scl_m = 1'b1;
    for (n = 0; n < 400 && scl !== 1'b1; n++)
      #100;
    #200;
    r = sda;
    #200;
    scl_m = 1'b0;
    #200;
  endtask
  // Start: SDA falls while SCL is high.
  task automatic start();
    sda_m = 1'b1;
    scl_m = 1'b1;
    #400;
    sda_m = 1'b0;
    #400;
    scl_m = 1'b0;
    #200;
  endtask
  // Stop: SDA rises while SCL is high.
  task automatic stop();
    sda_m = 1'b0;
    #400;
    scl_m = 1'b1;
    #400;
    sda_m = 1'b1;
    #400;
  endtask
  // Byte out, most significant bit first, then the slave's answer.
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then our own acknowledge or refusal.
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

// file: tb/i2c_port_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_port_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe_n,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire pins_to_port,
  input wire slew_limit_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite;
  wire rel = wr && (paddr == 8'h08 || (paddr == 8'h00 && pwdata[4]));
  logic [3:0] mode_q;
  logic [7:0] mask_q;
  logic [7:0] adr_q;
  logic [2:0] rel_q;
  logic en_q;
  logic phase_q;
  // Shadow of software fields; hardware never changes these, so they can be tracked here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 4'h0;
      en_q <= 1'b0;
      phase_q <= 1'b0;
      mask_q <= 8'hFF;
      adr_q <= 8'h00;
      rel_q <= 3'h0;
    end else begin
      rel_q <= {rel_q[1:0], rel};
      if (wr && paddr == 8'h00) begin
        mode_q <= pwdata[3:0];
        en_q <= pwdata[5];
      end
      if (wr && paddr == 8'h04)
        phase_q <= pwdata[7];
      if (wr && paddr == 8'h08 && mode_q == 4'h9)
        mask_q <= pwdata[7:0];
      if (wr && paddr == 8'h08 && mode_q != 4'h9)
        adr_q <= pwdata[7:0];
    end
  end
  // A completed read of one location.
  sequence rd_at(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  chk_mask_window: assert property (
    rd_at(8'h08) |-> prdata == {24'h000000, (mode_q == 4'h9) ? mask_q : adr_q})
    else $error("address location returned the wrong register");
  chk_mode_readback: assert property (
    rd_at(8'h00) |-> prdata[3:0] == mode_q && prdata[5] == en_q)
    else $error("control read lost the mode or enable");
  chk_pins_follow: assert property (pins_to_port == en_q)
    else $error("pin ownership differs from the enable bit");
  chk_pins_released: assert property (!pins_to_port |=> scl_oe_n && sda_oe_n)
    else $error("disabled port still pulls a line");
  chk_slew_follow: assert property (slew_limit_en == !phase_q)
    else $error("slew limiting differs from the sample phase bit");
  chk_stretch_release: assert property (
    $rose(scl_oe_n) |-> rel_q != 3'h0 || !pins_to_port)
    else $error("clock released without a software release");
  chk_stretch_sync: assert property ($fell(scl_oe_n) |-> !$past(scl_in, 2))
    else $error("clock stretch began while SCL was high");
  chk_sda_low_phase: assert property ($changed(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("SDA drive changed while SCL was high");
endmodule
bind i2c_slave_serial_port i2c_port_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .pins_to_port(pins_to_port), .slew_limit_en(slew_limit_en));
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rdat;
  logic err;
  logic ack;
  logic [7:0] rb;
  logic [3:0] modes [5] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, sda_out, scl_oe_n, sda_oe_n, pins_to_port, slew_limit_en;
  wire scl_m, sda_m;
  // Open-drain lines with pull-ups; the pin direction follows the enables.
  wire scl = scl_m & (scl_oe_n | scl_out);
  wire sda = sda_m & (sda_oe_n | sda_out);
  i2c_slave_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pins_to_port(pins_to_port),
    .slew_limit_en(slew_limit_en));
  i2c_bus_master m (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  // The 10 MHz clock and a hang guard far beyond the expected run.
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  // One APB transfer; nothing is released before pready is seen at an edge or 20 cycles have passed.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    `CK("pready", 1'b1, pready)
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  // Read and compare the masked bits; the upper 24 bits must read zero.
  task automatic rchk(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CK($sformatf("reg %h", a), {24'h000000, e}, rdat & {24'hFFFFFF, k})
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Register map first, then write, refused, read, 10-bit and event traffic.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h00, 8'hFF, 8'h00);
    rchk(8'h04, 8'hFF, 8'h00);
    rchk(8'h08, 8'hFF, 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    `CK("pslverr", 1'b1, err)
    wr(8'h00, 8'h09);
    rchk(8'h08, 8'hFF, 8'hFF);
    wr(8'h08, 8'hF0);
    wr(8'h04, 8'h9F);
    rchk(8'h04, 8'hFF, 8'h80);
    `CK("slew", 1'b0, slew_limit_en)
    wr(8'h04, 8'h00);
    foreach (modes[i]) begin
      wr(8'h00, {4'h0, modes[i]});
      rchk(8'h00, 8'h0F, {4'h0, modes[i]});
    end
    wr(8'h00, 8'h36);
    wr(8'h08, 8'hA0);
    `CK("pins", 1'b1, pins_to_port)
    m.start();
    m.send(8'hAA, ack);
    `CK("ack", 1'b1, ack)
    rchk(8'h04, 8'h3F, 8'h09);
    rchk(8'h0C, 8'hFF, 8'hAA);
    m.send(8'h5C, ack);
    rchk(8'h04, 8'h3F, 8'h29);
    rchk(8'h10, 8'h01, 8'h01);
    rchk(8'h0C, 8'hFF, 8'h5C);
    rchk(8'h04, 8'h01, 8'h00);
    m.send(8'h11, ack);
    m.send(8'h22, ack);
    `CK("ack", 1'b0, ack)
    rchk(8'h00, 8'hFF, 8'h76);
    m.stop();
    rchk(8'h04, 8'h18, 8'h10);
    m.start();
    m.send(8'h52, ack);
    `CK("ack", 1'b0, ack)
    wr(8'h00, 8'h36);
    m.start();
    m.send(8'hA1, ack);
    `CK("ack", 1'b1, ack)
    rchk(8'h04, 8'h0C, 8'h0C);
    rchk(8'h00, 8'h10, 8'h00);
    `CK("stretch", 1'b0, scl_oe_n)
    wr(8'h0C, 8'h96);
    rchk(8'h04, 8'h01, 8'h01);
    wr(8'h00, 8'h36);
    wr(8'h0C, 8'h33);
    rchk(8'h00, 8'hFF, 8'hB6);
    `CK("stretch", 1'b1, scl_oe_n)
    m.recv(1'b1, rb);
    `CK("data", 8'h96, rb)
    rchk(8'h04, 8'h01, 8'h00);
    m.stop();
    wr(8'h00, 8'h37);
    wr(8'h08, 8'hF0);
    m.start();
    m.send(8'hF0, ack);
    `CK("ack", 1'b1, ack)
    rchk(8'h04, 8'h02, 8'h02);
    wr(8'h08, 8'hF0);
    m.stop();
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h3E);
    m.start();
    rchk(8'h10, 8'h01, 8'h01);
    rchk(8'h04, 8'h18, 8'h08);
    wr(8'h00, 8'h0E);
    rchk(8'h04, 8'h18, 8'h00);
    `CK("pins", 1'b0, pins_to_port)
    m.stop();
    end_sim();
  end
endmodule
`default_nettype wire
